/* rtl/eil_pkg.sv */
// constants and carrier types for the external interrupt edge latch
package eil_pkg;

  // pins, sources and bus sizes
  localparam int NPIN   = 4;
  localparam int NPER   = 4;
  localparam int NSRC   = 6;
  localparam int ADDR_W = 5;

  // register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CFG   = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_PRI   = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_ISTAT = 5'h0c;
  localparam logic [ADDR_W-1:0] ADDR_IMASK = 5'h10;

  // field positions
  localparam int CFG_EN_LSB    = 0;
  localparam int CFG_RISE_LSB  = 4;
  localparam int PRI_FLD_W     = 2;
  localparam int ST_LATCH_LSB  = 0;
  localparam int ST_VALID_BIT  = 2;
  localparam int ST_ID_LSB     = 3;
  localparam int ST_LVL_LSB    = 6;
  localparam int IS_SET_LSB    = 0;
  localparam int IS_OVR_LSB    = 2;

  // values after reset
  localparam logic [7:0]  CFG_RST   = 8'h00;
  localparam logic [11:0] PRI_RST   = 12'h000;
  localparam logic [3:0]  IMASK_RST = 4'h0;

  // pin i feeds external interrupt 1 when its bit is set, else 0
  localparam logic [NPIN-1:0] PIN_TO_EXT1 = 4'ha;

  // source indices: lower index wins among equal priorities
  localparam logic [2:0] SRC_EXT1 = 3'h0;
  localparam logic [2:0] SRC_EXT0 = 3'h1;
  localparam logic [2:0] SRC_PER0 = 3'h2;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // enable bits and rising-edge selects, one per pin
  typedef struct packed {
    logic [NPIN-1:0] rise;
    logic [NPIN-1:0] en;
  } eil_cfg_t;

  // request presented to the processor core
  typedef struct packed {
    logic       valid;
    logic [2:0] id;
    logic [1:0] lvl;
  } eil_cpu_req_t;

endpackage

/* rtl/eil_top.sv */
// external interrupt edge latches, priority arbiter and register slave
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps

module eil_top
  import eil_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [NPIN-1:0]   ext_pin,
  input  wire logic [NPER-1:0]   per_req,
  input  wire logic [1:0]        cpu_pri,
  input  wire logic              cpu_ack,
  output eil_cpu_req_t           cpu_req,
  output logic [NPER-1:0]        per_ack,
  output logic                   irq
);

  eil_cfg_t          cfg_q;
  logic [11:0]       pri_q;
  logic [3:0]        istat_q;
  logic [3:0]        imask_q;
  logic [NPIN-1:0]   sync0_q;
  logic [NPIN-1:0]   sync1_q;
  logic [NPIN-1:0]   prev_q;
  logic [NPIN-1:0]   hit;
  logic [1:0]        ext_set;
  logic [1:0]        ext_clr;
  logic [1:0]        ext_q;
  logic [NSRC-1:0]   pend;
  logic              found;
  logic [2:0]        best_id;
  logic [1:0]        best_lvl;
  eil_cpu_req_t      req_q;
  logic [NPER-1:0]   per_ack_q;
  logic              take;
  logic [3:0]        ev;
  logic              irq_q;
  logic              awready_q;
  logic              wready_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              do_wr;
  logic [31:0]       wmask;
  logic [31:0]       wbits;
  logic              wr_cfg;
  logic              wr_pri;
  logic              wr_istat;
  logic              wr_imask;
  logic              wr_hit;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rd_word;
  logic              rd_hit;

  // two flops bring the pins into the clock domain; the third stage
  // keeps the previous settled level so the detector never sees sync0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync0_q <= '0;
      sync1_q <= '0;
      prev_q  <= '0;
    end else begin
      sync0_q <= ext_pin;
      sync1_q <= sync0_q;
      prev_q  <= sync1_q;
    end
  end

  // one detector per pin, each with its own edge select
  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_edge
      always_comb begin
        if (cfg_q.rise[gp]) begin
          hit[gp] = cfg_q.en[gp] & sync1_q[gp] & ~prev_q[gp];
        end else begin
          hit[gp] = cfg_q.en[gp] & ~sync1_q[gp] & prev_q[gp];
        end
      end
    end
  endgenerate

  // pins fold onto two request lines by a fixed map
  assign ext_set[0] = |(hit & ~PIN_TO_EXT1);
  assign ext_set[1] = |(hit & PIN_TO_EXT1);

  // the core takes exactly the request held in req_q, so the clear is
  // decoded from that frozen id; a different source being serviced or
  // a new request arriving can never steer the clear elsewhere
  assign take       = cpu_ack & req_q.valid;
  assign ext_clr[0] = take & (req_q.id == SRC_EXT0);
  assign ext_clr[1] = take & (req_q.id == SRC_EXT1);

  // each latch has its own set and clear; a fresh edge in the cycle
  // of the clear wins, so no edge is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_q <= '0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (ext_set[k]) begin
          ext_q[k] <= 1'b1;
        end else if (ext_clr[k]) begin
          ext_q[k] <= 1'b0;
        end
      end
    end
  end

  // ext 1 at index 0, ext 0 at index 1, peripherals above
  assign pend = {per_req, ext_q[0], ext_q[1]};

  // scan downward with >= so the lowest index wins a tie; level 0
  // means the source is disabled
  always_comb begin
    logic [1:0] lvl;
    lvl      = 2'h0;
    found    = 1'b0;
    best_id  = SRC_EXT1;
    best_lvl = 2'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      lvl = pri_q[i*PRI_FLD_W +: PRI_FLD_W];
      if (pend[i] && lvl != 2'h0 && lvl >= best_lvl) begin
        found    = 1'b1;
        best_id  = 3'(i);
        best_lvl = lvl;
      end
    end
  end

  // a request is frozen while presented so the later clear targets
  // the right source; the price is that a higher request arriving
  // meanwhile waits for this one to be taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q <= '0;
    end else if (!req_q.valid) begin
      if (found && best_lvl > cpu_pri) begin
        req_q.valid <= 1'b1;
        req_q.id    <= best_id;
        req_q.lvl   <= best_lvl;
      end
    end else if (take) begin
      req_q.valid <= 1'b0;
    end
  end

  // peripherals learn of their service by a one-cycle pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_ack_q <= '0;
    end else begin
      for (int p = 0; p < NPER; p++) begin
        per_ack_q[p] <= take && (req_q.id == SRC_PER0 + 3'(p));
      end
    end
  end

  // events: each latch set, and an edge landing on a full latch
  assign ev[IS_SET_LSB +: 2] = ext_set;
  assign ev[IS_OVR_LSB +: 2] = ext_set & ext_q & ~ext_clr;

  // sticky bits, write one to clear; a new event beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_q <= '0;
    end else if (wr_istat) begin
      istat_q <= (istat_q & ~wbits[3:0]) | ev;
    end else begin
      istat_q <= istat_q | ev;
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(istat_q & imask_q);
    end
  end

  // address and data are taken independently, in either order
  assign do_wr = !awready_q && !wready_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      awaddr_q  <= '0;
    end else if (awready_q && s_axi_awvalid) begin
      awready_q <= 1'b0;
      awaddr_q  <= s_axi_awaddr;
    end else if (do_wr) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (wready_q && s_axi_wvalid) begin
      wready_q <= 1'b0;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_wr) begin
      wready_q <= 1'b1;
    end
  end

  // byte enables become a bit mask; unselected lanes keep old bits
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wstrb_q[b]}};
    end
    wbits = wdata_q & wmask;
  end

  // decode on the word address; low two bits are ignored
  always_comb begin
    logic [ADDR_W-1:0] wa;
    wa       = {awaddr_q[ADDR_W-1:2], 2'b00};
    wr_cfg   = do_wr && (wa == ADDR_CFG);
    wr_pri   = do_wr && (wa == ADDR_PRI);
    wr_istat = do_wr && (wa == ADDR_ISTAT);
    wr_imask = do_wr && (wa == ADDR_IMASK);
    wr_hit   = wr_cfg || wr_pri || wr_istat || wr_imask ||
               (wa == ADDR_STATE);
  end

  // write answer: unmapped offsets get an error, state is read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // edge enables and polarities
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= CFG_RST;
    end else if (wr_cfg) begin
      cfg_q <= (cfg_q & ~wmask[7:0]) | wbits[7:0];
    end
  end

  // two bits of priority per source, ext 1 in the lowest field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_q <= PRI_RST;
    end else if (wr_pri) begin
      pri_q <= (pri_q & ~wmask[11:0]) | wbits[11:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imask_q <= IMASK_RST;
    end else if (wr_imask) begin
      imask_q <= (imask_q & ~wmask[3:0]) | wbits[3:0];
    end
  end

  always_comb begin
    logic [ADDR_W-1:0] ra;
    ra      = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    rd_word = '0;
    rd_hit  = 1'b1;
    case (ra)
      ADDR_CFG:   rd_word[7:0]  = cfg_q;
      ADDR_PRI:   rd_word[11:0] = pri_q;
      ADDR_STATE: begin
        rd_word[ST_LATCH_LSB +: 2] = ext_q;
        rd_word[ST_VALID_BIT]      = req_q.valid;
        rd_word[ST_ID_LSB +: 3]    = req_q.id;
        rd_word[ST_LVL_LSB +: 2]   = req_q.lvl;
      end
      ADDR_ISTAT: rd_word[3:0]  = istat_q;
      ADDR_IMASK: rd_word[3:0]  = imask_q;
      default:    rd_hit        = 1'b0;
    endcase
  end

  // one read at a time; data is captured when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (arready_q && s_axi_arvalid) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // all outputs come straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign cpu_req       = req_q;
  assign per_ack       = per_ack_q;
  assign irq           = irq_q;

endmodule

/* dv/eil_asserts.sv */
// concurrent checks on the ports of the interrupt latch block
`timescale 1ns/1ps
module eil_asserts
  import eil_pkg::*;
(
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [1:0]      s_axi_rresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic [1:0]      cpu_pri,
  input wire logic            cpu_ack,
  input wire eil_cpu_req_t    cpu_req,
  input wire logic [NPER-1:0] per_ack
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // the core takes a request, or leaves it standing
  sequence s_take;
    cpu_req.valid && cpu_ack;
  endsequence
  sequence s_wait;
    cpu_req.valid && !cpu_ack;
  endsequence
  ack_clear_a: assert property (s_take |=> !cpu_req.valid)
    else $error("request still shown after it was taken");
  req_hold_a: assert property (s_wait |=> cpu_req.valid && $stable(cpu_req))
    else $error("standing request changed before it was taken");
  lvl_above_a: assert property ($rose(cpu_req.valid) |->
    cpu_req.lvl > $past(cpu_pri)) else $error("request not above core level");
  id_range_a: assert property (cpu_req.valid |-> cpu_req.id < NSRC)
    else $error("request names no source");
  per_pulse_a: assert property (s_take ##0 cpu_req.id >= SRC_PER0 |=>
    per_ack == 4'h1 << ($past(cpu_req.id) - SRC_PER0))
    else $error("wrong peripheral acknowledged");
  ext_quiet_a: assert property (s_take ##0 cpu_req.id < SRC_PER0 |=>
    per_ack == 4'h0) else $error("peripheral acknowledged for external");
  per_cause_a: assert property (per_ack != 4'h0 |-> $past(cpu_ack))
    else $error("peripheral acknowledged without a take");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rresp)) else $error("read answer dropped");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
endmodule

/* dv/eil_core_model.sv */
// processor core model: takes a presented request after a set delay
`timescale 1ns/1ps
module eil_core_model
  import eil_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire eil_cpu_req_t cpu_req,
  input  wire logic [3:0]   ack_dly,
  output logic              cpu_ack
);
  logic [3:0] wait_q;
  // one-cycle take pulse; a slow delay widens the race window
  always_ff @(posedge aclk) begin
    if (!aresetn || !cpu_req.valid || cpu_ack) begin
      wait_q  <= 4'h0;
      cpu_ack <= 1'b0;
    end else begin
      wait_q  <= wait_q + 4'h1;
      cpu_ack <= (wait_q >= ack_dly);
    end
  end
endmodule

/* dv/eil_top_tb.sv */
// self-checking bench for the external interrupt edge latch
`timescale 1ns/1ps
module eil_top_tb
  import eil_pkg::*;
;
  localparam logic [31:0] ALL = 32'hffffffff;
  localparam logic [31:0] STL = 32'h00000007;
  logic aclk = 1'b0, aresetn = 1'b0, cpu_ack, irq;
  logic [ADDR_W-1:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, ext_pin = 4'h0, per_req = 4'h0;
  logic [3:0] ack_dly = 4'h0, per_ack;
  logic [1:0] s_axi_bresp, s_axi_rresp, cpu_pri = 2'h0;
  eil_cpu_req_t cpu_req;
  logic [2:0] taken_q[$];
  int mismatches = 0, samples_checked = 0, cyc = 0;
  eil_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_pin, .per_req,
    .cpu_pri, .cpu_ack, .cpu_req, .per_ack, .irq);
  eil_core_model core (.aclk, .aresetn, .cpu_req, .ack_dly, .cpu_ack);
  always #5 aclk = ~aclk;
  // log every take; the peripheral clears its flag as the core takes
  // it, since a flag dropped only on per_ack would be presented again
  always @(posedge aclk) begin
    if (aresetn && cpu_req.valid && cpu_ack) begin
      taken_q.push_back(cpu_req.id);
      if (cpu_req.id == SRC_PER0) per_req[0] <= 1'b0;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit ad, wd;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(s_axi_rdata & m, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask
  // next source the core took; the watchdog bounds the wait
  task automatic take(input logic [2:0] id);
    while (taken_q.size() == 0) @(posedge aclk);
    chk({29'h0, taken_q.pop_front()}, {29'h0, id});
  endtask
  task automatic quiet();
    repeat (20) @(posedge aclk);
    chk(taken_q.size(), 32'h0);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CFG, 32'h0, ALL, RESP_OKAY);
    rd(ADDR_PRI, 32'h0, ALL, RESP_OKAY);
    rd(ADDR_STATE, 32'h0, ALL, RESP_OKAY);
    rd(ADDR_ISTAT, 32'h0, ALL, RESP_OKAY);
    rd(ADDR_IMASK, 32'h0, ALL, RESP_OKAY);
    rd(5'h14, 32'h0, ALL, RESP_SLVERR);
    wr(5'h14, ALL, RESP_SLVERR);
    wr(ADDR_STATE, 32'hff, RESP_OKAY);
    // only the second byte lane lands; the other lanes keep old bits
    s_axi_wstrb <= 4'h2;
    wr(ADDR_PRI, ALL, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(ADDR_PRI, 32'h00000f00, ALL, RESP_OKAY);
    rd(ADDR_STATE, 32'h0, ALL, RESP_OKAY);
    $display("test registers done");
    // pins 0,1 rising, 2,3 falling; both externals at level 3
    wr(ADDR_CFG, 32'h3f, RESP_OKAY);
    wr(ADDR_PRI, 32'h01f, RESP_OKAY);
    wr(ADDR_IMASK, 32'h3, RESP_OKAY);
    rd(ADDR_PRI, 32'h01f, ALL, RESP_OKAY);
    ext_pin <= 4'h1;
    take(SRC_EXT0);
    rd(ADDR_STATE, 32'h0, STL, RESP_OKAY);
    rd(ADDR_ISTAT, 32'h1, ALL, RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_ISTAT, 32'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    ext_pin <= 4'h0;
    quiet();
    $display("test single edge done");
    ext_pin <= 4'h3;
    take(SRC_EXT1);
    take(SRC_EXT0);
    quiet();
    $display("test tied pins done");
    cpu_pri <= 2'h3;
    ext_pin <= 4'hf;
    repeat (4) @(posedge aclk);
    ext_pin <= 4'h3;
    quiet();
    cpu_pri <= 2'h2;
    take(SRC_EXT1);
    take(SRC_EXT0);
    $display("test falling edges done");
    // lower level peripheral taken slowly while an edge lands
    cpu_pri <= 2'h0;
    ack_dly <= 4'h4;
    ext_pin <= 4'h7;
    per_req <= 4'h1;
    while (cpu_req.valid !== 1'b1) @(posedge aclk);
    ext_pin <= 4'h3;
    take(SRC_PER0);
    take(SRC_EXT0);
    quiet();
    $display("test lower service done");
    // higher level peripheral arrives while ext 0 is being taken
    wr(ADDR_PRI, 32'h035, RESP_OKAY);
    ext_pin <= 4'h7;
    repeat (4) @(posedge aclk);
    ext_pin <= 4'h3;
    while (cpu_req.valid !== 1'b1) @(posedge aclk);
    per_req <= 4'h1;
    take(SRC_EXT0);
    take(SRC_PER0);
    quiet();
    $display("test higher arrival done");
    rd(ADDR_ISTAT, 32'h3, 32'h3, RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_IMASK, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_ISTAT, 32'hf, RESP_OKAY);
    rd(ADDR_ISTAT, 32'h0, ALL, RESP_OKAY);
    $display("test interrupt line done");
    // a second edge on a latch still held raises the overrun event
    cpu_pri <= 2'h3;
    repeat (2) begin
      ext_pin <= 4'h2;
      repeat (4) @(posedge aclk);
      ext_pin <= 4'h3;
      repeat (4) @(posedge aclk);
    end
    rd(ADDR_ISTAT, 32'h5, ALL, RESP_OKAY);
    cpu_pri <= 2'h0;
    take(SRC_EXT0);
    quiet();
    $display("test overrun done");
    results();
  end
endmodule
bind eil_top eil_asserts u_chk (.aclk, .aresetn, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .cpu_pri, .cpu_ack,
  .cpu_req, .per_ack);
